/* dbwm_defines.svh */
`ifndef DBWM_DEFINES_SVH
`define DBWM_DEFINES_SVH

// ==========================================
// array geometry
`define DBWM_DW 36
`define DBWM_AW 4
`define DBWM_LANES 4
`define DBWM_LANE_W 9
`define DBWM_NARROW_LANES 4'h3
`define DBWM_ALL_LANES 4'hF
`define DBWM_BUF_DEPTH 2'h2

// ==========================================
// register bus
`define DBWM_AXI_AW 8
`define DBWM_OFS_CTRL 8'h00
`define DBWM_OFS_STATUS 8'h04
`define DBWM_OFS_PEEK_ADDR 8'h08
`define DBWM_OFS_PEEK_DATA 8'h0C
`define DBWM_RESP_OKAY 2'h0
`define DBWM_RESP_SLVERR 2'h2

// ==========================================
// fields and reset values
`define DBWM_CTRL_WIDE_BIT 0
`define DBWM_CTRL_HOLD_BIT 1
`define DBWM_CTRL_WIDE_RST 1'h1
`define DBWM_CTRL_HOLD_RST 1'h0
`define DBWM_STAT_SINGLE_BIT 0
`define DBWM_STAT_LEVEL_LSB 1
`define DBWM_STAT_BUSY_BIT 3
`define DBWM_STAT_COUNT_LSB 8

// ==========================================
// timing
`define DBWM_STRAP_WAIT 2'h3

`endif

/* dbwm_pkg.sv */
package dbwm_pkg;
`include "dbwm_defines.svh"

    // ==========================================
    // states
    typedef enum logic [0:0] {
        WR_IDLE,
        WR_BEAT1
    } dbwm_wr_state_t;

    typedef enum logic [2:0] {
        RD_IDLE,
        RD_WAIT,
        RD_ARM,
        RD_BEAT0,
        RD_BEAT1
    } dbwm_rd_state_t;

    // ==========================================
    // carriers
    typedef struct packed {
        logic k;
        logic k_n;
        logic c;
        logic c_n;
        logic wsel_n;
        logic rsel_n;
        logic [`DBWM_LANES-1:0] lane_sel_n;
        logic [`DBWM_AW-1:0] addr;
        logic [`DBWM_DW-1:0] d;
    } dbwm_pin_t;

    typedef struct packed {
        logic [`DBWM_AW-1:0] a;
        logic [`DBWM_DW-1:0] d0;
        logic [`DBWM_LANES-1:0] m0;
        logic [`DBWM_DW-1:0] d1;
        logic [`DBWM_LANES-1:0] m1;
    } dbwm_entry_t;

    typedef struct packed {
        dbwm_pin_t s1;
        dbwm_pin_t s2;
        logic k_d;
        logic k_n_d;
        logic c_d;
        logic c_n_d;
        logic [1:0] strap_cnt;
        logic strap_done;
        logic single;
        dbwm_wr_state_t wst;
        logic [`DBWM_DW-1:0] d0;
        logic [`DBWM_LANES-1:0] m0;
        dbwm_entry_t [1:0] fifo;
        logic wr_ptr;
        logic rd_ptr;
        logic [1:0] count;
        logic [7:0] burst_cnt;
        dbwm_rd_state_t rst;
        logic [`DBWM_AW-1:0] raddr;
        logic [`DBWM_DW-1:0] q;
        logic q_oe_n;
        logic org_wide;
        logic hold;
        logic [`DBWM_AW-1:0] peek;
        logic aw_got;
        logic [`DBWM_AXI_AW-1:0] aw_a;
        logic w_got;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } dbwm_state_t;

endpackage

/* dbwm_top.sv */
`timescale 1ns/10ps
`include "dbwm_defines.svh"
module dbwm_top (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    // memory pins
    input wire logic k_i,
    input wire logic k_n_i,
    input wire logic c_i,
    input wire logic c_n_i,
    input wire logic write_port_select_n_i,
    input wire logic read_port_select_n_i,
    input wire logic [`DBWM_LANES-1:0] byte_lane_select_n_i,
    input wire logic [`DBWM_AW-1:0] addr_i,
    input wire logic [`DBWM_DW-1:0] d_i,
    output logic [`DBWM_DW-1:0] q_o,
    output logic q_oe_n_o,
    output logic write_ready_o,
    // axi4-lite slave
    input wire logic [`DBWM_AXI_AW-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [`DBWM_AXI_AW-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i
);
    import dbwm_pkg::*;

    localparam int DEPTH = 1 << `DBWM_AW;
    localparam int LW = `DBWM_LANE_W;

    // ==========================================
    // state and array
    dbwm_state_t r;
    dbwm_state_t n;
    dbwm_pin_t pin_now;
    dbwm_entry_t ent;
    dbwm_entry_t c_ent;
    logic [`DBWM_DW-1:0] mem [DEPTH];
    logic [`DBWM_AW-1:0] c_a1;
    logic [`DBWM_AW-1:0] r_a1;
    logic [`DBWM_LANES-1:0] lane_ok;
    logic [`DBWM_LANES-1:0] m_now;
    logic k_rise;
    logic k_n_rise;
    logic ref_rise;
    logic ref_n_rise;
    logic push;
    logic commit;
    logic awready;
    logic wready;
    logic arready;
    logic [31:0] rd_word;
    logic rd_hit;
    logic wr_hit;

    assign pin_now = '{k: k_i, k_n: k_n_i, c: c_i, c_n: c_n_i,
                       wsel_n: write_port_select_n_i,
                       rsel_n: read_port_select_n_i,
                       lane_sel_n: byte_lane_select_n_i,
                       addr: addr_i, d: d_i};

    // ==========================================
    // edge detection on synchronised pins
    assign k_rise = r.s2.k & ~r.k_d;
    assign k_n_rise = r.s2.k_n & ~r.k_n_d;
    assign ref_rise = r.single ? k_rise : (r.s2.c & ~r.c_d);
    assign ref_n_rise = r.single ? k_n_rise : (r.s2.c_n & ~r.c_n_d);

    // ==========================================
    // buffer handshake
    assign write_ready_o = (r.count != `DBWM_BUF_DEPTH) & r.strap_done;
    assign commit = (r.count != 2'h0) & ~r.hold;
    assign c_ent = r.fifo[r.rd_ptr];
    assign c_a1 = c_ent.a + `DBWM_AW'(1);
    assign r_a1 = r.raddr + `DBWM_AW'(1);

    // narrow organisation masks the upper two lanes
    assign lane_ok = r.org_wide ? `DBWM_ALL_LANES : `DBWM_NARROW_LANES;
    assign m_now = r.s2.lane_sel_n | ~lane_ok;

    assign ent = '{a: r.s2.addr, d0: r.d0, m0: r.m0,
                   d1: r.s2.d, m1: m_now};

    // ==========================================
    // register decode
    assign awready = ~r.aw_got & ~r.bvalid;
    assign wready = ~r.w_got & ~r.bvalid;
    assign arready = ~r.rvalid;

    always_comb begin
        rd_hit = 1'b1;
        rd_word = 32'h0;
        unique case (s_axi_araddr_i)
            `DBWM_OFS_CTRL: begin
                rd_word[`DBWM_CTRL_WIDE_BIT] = r.org_wide;
                rd_word[`DBWM_CTRL_HOLD_BIT] = r.hold;
            end
            `DBWM_OFS_STATUS: begin
                rd_word[`DBWM_STAT_SINGLE_BIT] = r.single;
                rd_word[`DBWM_STAT_LEVEL_LSB +: 2] = r.count;
                rd_word[`DBWM_STAT_BUSY_BIT] = (r.wst != WR_IDLE);
                rd_word[`DBWM_STAT_COUNT_LSB +: 8] = r.burst_cnt;
            end
            `DBWM_OFS_PEEK_ADDR: begin
                rd_word[`DBWM_AW-1:0] = r.peek;
            end
            `DBWM_OFS_PEEK_DATA: begin
                rd_word = mem[r.peek][31:0];
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    assign wr_hit = (r.aw_a == `DBWM_OFS_CTRL) |
                    (r.aw_a == `DBWM_OFS_STATUS) |
                    (r.aw_a == `DBWM_OFS_PEEK_ADDR) |
                    (r.aw_a == `DBWM_OFS_PEEK_DATA);

    // ==========================================
    // next state
    always_comb begin
        n = r;
        push = 1'b0;
        n.s1 = pin_now;
        n.s2 = r.s1;
        n.k_d = r.s2.k;
        n.k_n_d = r.s2.k_n;
        n.c_d = r.s2.c;
        n.c_n_d = r.s2.c_n;

        // strap sampled once the synchroniser has filled
        if (!r.strap_done) begin
            n.strap_cnt = r.strap_cnt + 2'h1;
            if (r.strap_cnt == `DBWM_STRAP_WAIT) begin
                n.strap_done = 1'b1;
                n.single = r.s2.c & r.s2.c_n;
            end
        end

        // write port
        unique case (r.wst)
            WR_IDLE: begin
                if (k_rise && !r.s2.wsel_n && write_ready_o) begin
                    n.d0 = r.s2.d;
                    n.m0 = m_now;
                    n.wst = WR_BEAT1;
                end
            end
            WR_BEAT1: begin
                if (k_n_rise) begin
                    push = 1'b1;
                    n.fifo[r.wr_ptr] = ent;
                    n.wr_ptr = ~r.wr_ptr;
                    n.wst = WR_IDLE;
                end
            end
        endcase

        if (commit) begin
            n.rd_ptr = ~r.rd_ptr;
            n.burst_cnt = r.burst_cnt + 8'h01;
        end
        n.count = r.count + {1'b0, push} - {1'b0, commit};

        // read port, counted from the start cycle
        unique case (r.rst)
            RD_IDLE: begin
                if (k_rise && !r.s2.rsel_n && r.strap_done) begin
                    n.raddr = r.s2.addr;
                    n.rst = RD_WAIT;
                end
            end
            RD_WAIT: begin
                if (k_rise) begin
                    n.rst = RD_ARM;
                end
            end
            RD_ARM: begin
                if (ref_n_rise) begin
                    n.q = mem[r.raddr] & {{18{r.org_wide}}, 18'h3FFFF};
                    n.q_oe_n = 1'b0;
                    n.rst = RD_BEAT0;
                end
            end
            RD_BEAT0: begin
                if (ref_rise) begin
                    n.q = mem[r_a1] & {{18{r.org_wide}}, 18'h3FFFF};
                    n.rst = RD_BEAT1;
                end
            end
            RD_BEAT1: begin
                if (ref_n_rise) begin
                    n.q_oe_n = 1'b1;
                    n.rst = RD_IDLE;
                end
            end
        endcase

        // axi write channels
        if (s_axi_awvalid_i && awready) begin
            n.aw_got = 1'b1;
            n.aw_a = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && wready) begin
            n.w_got = 1'b1;
            n.w_data = s_axi_wdata_i;
            n.w_strb = s_axi_wstrb_i;
        end
        if (r.aw_got && r.w_got) begin
            n.aw_got = 1'b0;
            n.w_got = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = wr_hit ? `DBWM_RESP_OKAY : `DBWM_RESP_SLVERR;
            if (r.w_strb[0] && r.aw_a == `DBWM_OFS_CTRL) begin
                n.org_wide = r.w_data[`DBWM_CTRL_WIDE_BIT];
                n.hold = r.w_data[`DBWM_CTRL_HOLD_BIT];
            end
            if (r.w_strb[0] && r.aw_a == `DBWM_OFS_PEEK_ADDR) begin
                n.peek = r.w_data[`DBWM_AW-1:0];
            end
        end
        if (r.bvalid && s_axi_bready_i) begin
            n.bvalid = 1'b0;
        end

        // axi read channels
        if (s_axi_arvalid_i && arready) begin
            n.rvalid = 1'b1;
            n.rdata = rd_word;
            n.rresp = rd_hit ? `DBWM_RESP_OKAY : `DBWM_RESP_SLVERR;
        end else if (r.rvalid && s_axi_rready_i) begin
            n.rvalid = 1'b0;
        end
    end

    // ==========================================
    // state register
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            r <= '0;
            r.wst <= WR_IDLE;
            r.rst <= RD_IDLE;
            r.q_oe_n <= 1'b1;
            r.org_wide <= `DBWM_CTRL_WIDE_RST;
            r.hold <= `DBWM_CTRL_HOLD_RST;
        end else begin
            r <= n;
        end
    end

    // ==========================================
    // array commit, both beats at once
    always_ff @(posedge sys_clk_i) begin
        if (commit) begin
            for (int l = 0; l < `DBWM_LANES; l++) begin
                if (!c_ent.m0[l]) begin
                    mem[c_ent.a][l*LW +: LW] <= c_ent.d0[l*LW +: LW];
                end
                if (!c_ent.m1[l]) begin
                    mem[c_a1][l*LW +: LW] <= c_ent.d1[l*LW +: LW];
                end
            end
        end
    end

    // ==========================================
    // outputs
    assign q_o = r.q;
    assign q_oe_n_o = r.q_oe_n;
    assign s_axi_awready_o = awready;
    assign s_axi_wready_o = wready;
    assign s_axi_bvalid_o = r.bvalid;
    assign s_axi_bresp_o = r.bresp;
    assign s_axi_arready_o = arready;
    assign s_axi_rvalid_o = r.rvalid;
    assign s_axi_rdata_o = r.rdata;
    assign s_axi_rresp_o = r.rresp;

    // ==========================================
    // checks
    a_narrow_full: assert property (@(posedge sys_clk_i)
        disable iff (!resetn_i)
        commit && c_ent.m0 == 4'hC |=>
        mem[$past(c_ent.a)][17:0] == $past(c_ent.d0[17:0]))
        else $error("narrow full beat not written");

    a_narrow_low: assert property (@(posedge sys_clk_i)
        disable iff (!resetn_i)
        commit && c_ent.m0 == 4'hE |=>
        mem[$past(c_ent.a)][8:0] == $past(c_ent.d0[8:0]) &&
        mem[$past(c_ent.a)][17:9] == $past(mem[c_ent.a][17:9]))
        else $error("narrow low lane mismatch");

    a_narrow_high: assert property (@(posedge sys_clk_i)
        disable iff (!resetn_i)
        commit && c_ent.m0 == 4'hD |=>
        mem[$past(c_ent.a)][17:9] == $past(c_ent.d0[17:9]) &&
        mem[$past(c_ent.a)][8:0] == $past(mem[c_ent.a][8:0]))
        else $error("narrow high lane mismatch");

    a_narrow_none: assert property (@(posedge sys_clk_i)
        disable iff (!resetn_i)
        commit && !r.org_wide && c_ent.m0 == 4'hF |=>
        mem[$past(c_ent.a)][17:0] == $past(mem[c_ent.a][17:0]))
        else $error("masked narrow beat changed array");

    a_wide_full: assert property (@(posedge sys_clk_i)
        disable iff (!resetn_i)
        commit && c_ent.m0 == 4'h0 |=>
        mem[$past(c_ent.a)] == $past(c_ent.d0))
        else $error("wide full beat not written");

    a_wide_lane0: assert property (@(posedge sys_clk_i)
        disable iff (!resetn_i)
        commit && c_ent.m0 == 4'hE |=>
        mem[$past(c_ent.a)][35:9] == $past(mem[c_ent.a][35:9]))
        else $error("wide lane 0 write touched other lanes");

    a_wide_lane2: assert property (@(posedge sys_clk_i)
        disable iff (!resetn_i)
        commit && c_ent.m0 == 4'hB |=>
        mem[$past(c_ent.a)][26:18] == $past(c_ent.d0[26:18]) &&
        mem[$past(c_ent.a)][35:27] == $past(mem[c_ent.a][35:27]) &&
        mem[$past(c_ent.a)][17:0] == $past(mem[c_ent.a][17:0]))
        else $error("wide lane 2 write mismatch");

    a_wide_none: assert property (@(posedge sys_clk_i)
        disable iff (!resetn_i)
        commit && c_ent.m0 == 4'hF |=>
        mem[$past(c_ent.a)] == $past(mem[c_ent.a]))
        else $error("masked wide beat changed array");

    a_second_beat: assert property (@(posedge sys_clk_i)
        disable iff (!resetn_i)
        commit && c_ent.m1 == 4'h0 && c_ent.m0 == 4'hF |=>
        mem[$past(c_a1)] == $past(c_ent.d1))
        else $error("second beat not at next address");

    a_beat_capture: assert property (@(posedge sys_clk_i)
        disable iff (!resetn_i)
        r.wst == WR_IDLE && k_rise && !r.s2.wsel_n && write_ready_o |=>
        r.wst == WR_BEAT1 && r.d0 == $past(r.s2.d))
        else $error("first write beat not captured");

    a_out_idle: assert property (@(posedge sys_clk_i)
        disable iff (!resetn_i)
        r.rst inside {RD_IDLE, RD_WAIT, RD_ARM} |-> r.q_oe_n)
        else $error("read output driven while idle");

    a_out_launch: assert property (@(posedge sys_clk_i)
        disable iff (!resetn_i)
        $fell(r.q_oe_n) |-> $past(ref_n_rise) && $past(r.rst == RD_ARM))
        else $error("read data launched off output clock");

endmodule

/* dbwm_ctl_model.sv */
`timescale 1ns/10ps
module dbwm_ctl_model (
    // clock
    input wire logic sys_clk_i,
    // read data
    input wire logic [35:0] q_i,
    input wire logic q_oe_n_i,
    // memory pins
    output dbwm_pkg::dbwm_pin_t pins_o
);
    import dbwm_pkg::*;
    localparam int H = 6;
    logic [35:0] smp_q;
    logic smp_oe;

    // ==========================================
    // idle pins, output clocks strapped high
    initial begin
        pins_o = '0;
        pins_o.k_n = 1'b1;
        pins_o.c = 1'b1;
        pins_o.c_n = 1'b1;
        pins_o.wsel_n = 1'b1;
        pins_o.rsel_n = 1'b1;
        pins_o.lane_sel_n = 4'hF;
    end

    // ==========================================
    // one clock phase, sampling read data before it ends
    task automatic half(input logic v);
        repeat (H - 1) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        smp_q = q_i;
        smp_oe = q_oe_n_i;
        @(posedge sys_clk_i);
        pins_o.k <= v;
        pins_o.k_n <= ~v;
    endtask

    // ==========================================
    // write burst, one mask per beat
    task automatic wr(input logic [3:0] a, input logic [35:0] d0,
                      input logic [3:0] m0, input logic [35:0] d1,
                      input logic [3:0] m1);
        @(posedge sys_clk_i);
        pins_o.wsel_n <= 1'b0;
        pins_o.addr <= a;
        pins_o.d <= d0;
        pins_o.lane_sel_n <= m0;
        pins_o.k <= 1'b1;
        pins_o.k_n <= 1'b0;
        half(1'b0);
        pins_o.d <= d1;
        pins_o.lane_sel_n <= m1;
        half(1'b0);
        pins_o.wsel_n <= 1'b1;
        pins_o.d <= ~d1;
        pins_o.lane_sel_n <= ~m1;
    endtask

    // ==========================================
    // read burst, single-clock mode
    task automatic rd(input logic [3:0] a, output logic [35:0] q0,
                      output logic [35:0] q1, output logic oe0,
                      output logic oe1);
        @(posedge sys_clk_i);
        pins_o.rsel_n <= 1'b0;
        pins_o.addr <= a;
        pins_o.k <= 1'b1;
        pins_o.k_n <= 1'b0;
        half(1'b0);
        half(1'b1);
        pins_o.rsel_n <= 1'b1;
        half(1'b0);
        half(1'b1);
        q0 = smp_q;
        oe0 = smp_oe;
        half(1'b0);
        q1 = smp_q;
        half(1'b0);
        oe1 = smp_oe;
    endtask
endmodule

/* dbwm_tb.sv */
`timescale 1ns/10ps
`include "dbwm_defines.svh"
module dbwm_tb;
    import dbwm_pkg::*;
    logic sys_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    dbwm_pin_t pins;
    logic [35:0] q;
    logic q_oe_n;
    logic wready;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awready, wready_ax, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    int errors = 0;
    int checks_done = 0;
    int nb = 0;
    logic narrow = 1'b0;
    logic [35:0] exp_mem [16];

    always #2 sys_clk_i = ~sys_clk_i;

    dbwm_ctl_model dbwm_ctl_model_i (
        .sys_clk_i(sys_clk_i),
        .q_i(q),
        .q_oe_n_i(q_oe_n),
        .pins_o(pins)
    );

    dbwm_top dbwm_top_i (
        .sys_clk_i(sys_clk_i),
        .resetn_i(resetn_i),
        .k_i(pins.k),
        .k_n_i(pins.k_n),
        .c_i(pins.c),
        .c_n_i(pins.c_n),
        .write_port_select_n_i(pins.wsel_n),
        .read_port_select_n_i(pins.rsel_n),
        .byte_lane_select_n_i(pins.lane_sel_n),
        .addr_i(pins.addr),
        .d_i(pins.d),
        .q_o(q),
        .q_oe_n_o(q_oe_n),
        .write_ready_o(wready),
        .s_axi_awaddr_i(awaddr),
        .s_axi_awvalid_i(awvalid),
        .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(4'hF),
        .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready_ax),
        .s_axi_bresp_o(bresp),
        .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr),
        .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready)
    );

    // ==========================================
    // helpers
    task automatic chk(input string nm, input logic [35:0] e,
                       input logic [35:0] g);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v,
                          input logic [1:0] er);
        logic ta, tw, tb;
        logic [1:0] r;
        tb = 1'b0;
        @(posedge sys_clk_i);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (tb !== 1'b1) begin
            @(negedge sys_clk_i);
            ta = awready;
            tw = wready_ax;
            tb = bvalid;
            r = bresp;
            @(posedge sys_clk_i);
            if (ta === 1'b1) awvalid <= 1'b0;
            if (tw === 1'b1) wvalid <= 1'b0;
        end
        bready <= 1'b0;
        chk("bresp", {34'h0, er}, {34'h0, r});
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                          input logic [1:0] er);
        logic ta, tr;
        logic [1:0] r;
        tr = 1'b0;
        @(posedge sys_clk_i);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (tr !== 1'b1) begin
            @(negedge sys_clk_i);
            ta = arready;
            tr = rvalid;
            d = rdata;
            r = rresp;
            @(posedge sys_clk_i);
            if (ta === 1'b1) arvalid <= 1'b0;
        end
        rready <= 1'b0;
        chk("rresp", {34'h0, er}, {34'h0, r});
    endtask

    task automatic wr(input logic [3:0] a, input logic [35:0] d0,
                      input logic [3:0] m0, input logic [35:0] d1,
                      input logic [3:0] m1);
        logic [3:0] a1;
        logic [3:0] keep;
        a1 = a + 4'h1;
        keep = narrow ? 4'hC : 4'h0;
        for (int i = 0; i < 50 && wready !== 1'b1; i++) begin
            @(negedge sys_clk_i);
        end
        chk("write_ready", 36'h1, {35'h0, wready});
        dbwm_ctl_model_i.wr(a, d0, m0, d1, m1);
        for (int l = 0; l < 4; l++) begin
            if (!(m0[l] | keep[l])) exp_mem[a][l*9+:9] = d0[l*9+:9];
            if (!(m1[l] | keep[l])) exp_mem[a1][l*9+:9] = d1[l*9+:9];
        end
        nb++;
    endtask

    task automatic vfy(input logic [3:0] a);
        logic [35:0] q0, q1, k;
        logic o0, o1;
        logic [3:0] a1;
        a1 = a + 4'h1;
        k = narrow ? 36'h00003FFFF : 36'hFFFFFFFFF;
        dbwm_ctl_model_i.rd(a, q0, q1, o0, o1);
        chk("q_first", exp_mem[a] & k, q0);
        chk("q_second", exp_mem[a1] & k, q1);
        chk("oe_n_data", 36'h0, {35'h0, o0});
        chk("oe_n_after", 36'h1, {35'h0, o1});
    endtask

    // ==========================================
    // scenarios
    task automatic t_reset();
        logic [31:0] v;
        chk("oe_n_reset", 36'h1, {35'h0, q_oe_n});
        axi_rd(`DBWM_OFS_CTRL, v, `DBWM_RESP_OKAY);
        chk("ctrl_reset", 36'h1, {4'h0, v});
        axi_rd(8'h10, v, `DBWM_RESP_SLVERR);
        chk("unmapped", 36'h0, {4'h0, v});
        axi_wr(8'h10, 32'h0, `DBWM_RESP_SLVERR);
    endtask

    task automatic t_wide();
        logic [3:0] m0, m1;
        wr(4'hF, 36'h123456789, 4'h0, 36'hFEDCBA987, 4'h0);
        wr(4'h2, 36'h0A5A5A5A5, 4'h0, 36'h05A5A5A5A, 4'h0);
        wr(4'h2, 36'h0, 4'hF, 36'h3C3C3C3C3, 4'h0);
        vfy(4'h2);
        vfy(4'hF);
        for (int i = 0; i < 4; i++) begin
            m0 = ~(4'h1 << i);
            m1 = ~(4'h1 << ((i + 1) % 4));
            wr(4'hF, ~exp_mem[15], m0, ~exp_mem[0], m1);
            vfy(4'hF);
        end
        wr(4'hF, ~exp_mem[15], 4'hF, ~exp_mem[0], 4'hF);
        vfy(4'hF);
    endtask

    task automatic t_narrow();
        logic [3:0] nm [4] = '{4'hC, 4'hE, 4'hD, 4'hF};
        logic [31:0] v;
        axi_wr(`DBWM_OFS_CTRL, 32'h0, `DBWM_RESP_OKAY);
        narrow = 1'b1;
        for (int i = 0; i < 4; i++) begin
            wr(4'h2, ~exp_mem[2], nm[i], ~exp_mem[3], nm[(i + 1) % 4]);
            vfy(4'h2);
        end
        axi_wr(`DBWM_OFS_CTRL, 32'h1, `DBWM_RESP_OKAY);
        narrow = 1'b0;
        axi_wr(`DBWM_OFS_PEEK_ADDR, 32'h3, `DBWM_RESP_OKAY);
        axi_rd(`DBWM_OFS_PEEK_DATA, v, `DBWM_RESP_OKAY);
        chk("peek", {4'h0, exp_mem[3][31:0]}, {4'h0, v});
    endtask

    task automatic t_buffer();
        logic [31:0] v;
        wr(4'h8, 36'h0, 4'h0, 36'h0, 4'h0);
        axi_wr(`DBWM_OFS_CTRL, 32'h3, `DBWM_RESP_OKAY);
        wr(4'h4, 36'h2468ACE13, 4'h0, 36'h13579BDF0, 4'h0);
        wr(4'h6, 36'h13579BDF0, 4'h0, 36'h2468ACE13, 4'h0);
        repeat (4) @(negedge sys_clk_i);
        chk("ready_full", 36'h0, {35'h0, wready});
        axi_rd(`DBWM_OFS_STATUS, v, `DBWM_RESP_OKAY);
        chk("level", 36'h2, {34'h0, v[2:1]});
        dbwm_ctl_model_i.wr(4'h8, 36'hFFFFFFFFF, 4'h0, 36'hFFFFFFFFF, 4'h0);
        axi_wr(`DBWM_OFS_CTRL, 32'h1, `DBWM_RESP_OKAY);
        vfy(4'h4);
        vfy(4'h6);
        vfy(4'h8);
        axi_rd(`DBWM_OFS_STATUS, v, `DBWM_RESP_OKAY);
        chk("status", {20'h0, nb[7:0], 8'h01}, {20'h0, v[15:0]});
    endtask

    // ==========================================
    // run and verdict
    task automatic test_done();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        t_reset();
        t_wide();
        t_narrow();
        t_buffer();
        test_done();
    end

    initial begin
        repeat (20000) @(posedge sys_clk_i);
        errors++;
        test_done();
    end
endmodule
